// ==== uls_pkg.sv ====
// Shared constants and carrier types for the serial line status block
package uls_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] OFF_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFF_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFF_SCRATCH = 8'h08;
  localparam logic [7:0] OFF_DMA_READY = 8'h0c;
  localparam logic [7:0] OFF_CONFIG = 8'h10;

  // Line status field positions
  localparam int LSR_RX_FIFO_ERROR = 0;
  localparam int LSR_TRANSMITTER_EMPTY = 1;
  localparam int LSR_HOLDING_EMPTY = 2;
  localparam int LSR_BREAK_SEEN = 3;
  localparam int LSR_FRAMING_ERROR = 4;
  localparam int LSR_PARITY_ERROR = 5;
  localparam int LSR_OVERRUN = 6;
  localparam int LSR_RX_DATA_READY = 7;

  // Modem status and DMA ready field positions
  localparam int MSR_CLEAR_TO_SEND = 3;
  localparam int MSR_CLEAR_TO_SEND_DELTA = 7;
  localparam int DSR_TX_DMA_READY = 6;
  localparam int DSR_RX_DMA_READY = 7;

  // Values after reset
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;

  // Frame timing in baud ticks (16 ticks per bit)
  localparam int TICKS_PER_BIT = 16;
  localparam int START_STOP_BITS = 2;
  localparam int MIN_DATA_BITS = 5;
  localparam int TIMEOUT_CHARS = 4;

  // Receive trigger thresholds, in characters
  localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
  localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
  localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
  localparam logic [4:0] TRIG_LEVEL_3 = 5'h0e;

  // Error tags carried with each received character
  typedef struct packed {
    logic break_seen;
    logic framing_error;
    logic parity_error;
  } uls_tag_t;

  // Character completed by the receive shifter
  typedef struct packed {
    logic push;
    uls_tag_t tag;
  } uls_rx_evt_t;

  // Configuration register layout, bit 7 down to bit 0
  typedef struct packed {
    logic parity_en;
    logic [1:0] word_len;
    logic modem_status_irq_enable;
    logic [1:0] rx_trigger_level;
    logic dma_mode_select;
    logic fifo_enable;
  } uls_cfg_t;

endpackage

// ==== uls_tag_mem.sv ====
// Error-tag memory shadowing the receive FIFO, registered read port
`timescale 1ns/1ps
module uls_tag_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire uls_pkg::uls_tag_t wdata,
  input wire logic [AW-1:0] raddr,
  output uls_pkg::uls_tag_t rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][2:0] mem;
    logic [2:0] rd;
  } uls_mem_state_t;

  uls_mem_state_t s_r;
  uls_mem_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (we)
      s_nxt.mem[waddr] = wdata;
    // Write-first so a tag landing on the head is seen at once
    if (we && waddr == raddr)
      s_nxt.rd = wdata;
    else
      s_nxt.rd = s_r.mem[raddr];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  assign rdata = uls_pkg::uls_tag_t'(s_r.rd);

endmodule

// ==== uls_status.sv ====
// Line, modem and DMA status logic of one serial channel, APB slave
//
// Overview of operation
// - FIFO mode: receive FIFO error bit is high while any stored character has an error.
// - Transmitter empty only when holding store and shift register are both empty.
// - Holding empty once the held character moves out; FIFO mode: FIFO empty.
// - Break set when input low past a full frame; read clears, or good stop in non-FIFO mode.
// - After a break, no character loads until the input returns high.
// - FIFO mode stores one zero character per break; flag shows at head.
// - Framing error on bad first stop bit; cleared by read or new load.
// - FIFO mode raises framing error when that character reaches the head.
// - After framing error the low stop sample is taken as a start bit.
// - Parity error on mismatch, shown at head; read or new load clears.
// - Non-FIFO overrun when unread buffer is overwritten; only a read clears.
// - FIFO overrun when FIFO full and another character completes; FIFO kept.
// - Data ready while a character is held; cleared when all are read.
// - Clear-to-send status bit is the inverse of the active-low pin.
// - Delta bit set on pin change since last read; raises modem request.
// - Eight-bit scratch register, freely read and written, no side effects.
// - DMA mode 1 only when mode select and FIFO enable both set.
// - Mode 0 transmit ready: set with a character queued, clear when none.
// - Mode 1 transmit ready: set when FIFO full, clear when it drains.
// - Mode 0 receive ready while nothing is held, clear once one arrives.
// - Mode 1 receive ready until trigger or time-out, then clear until empty.
// - Trigger field picks 1, 4, 8 or 14 characters.
// - Time-out after four character times with no FIFO traffic.
`timescale 1ns/1ps
module uls_status #(
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_input_pin,
  input wire logic baud_tick,
  input wire uls_pkg::uls_rx_evt_t rx_evt,
  input wire logic rx_buf_read,
  input wire logic tx_write,
  input wire logic tx_load_shift,
  input wire logic tx_shift_busy,
  input wire logic cts_n,
  output logic rx_zero_push,
  output logic rx_hold_off,
  output logic rx_resync,
  output logic rx_timeout,
  output logic modem_status_irq,
  output logic tx_dma_ready,
  output logic rx_dma_ready,
  output logic fifo_enable
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  typedef struct packed {
    uls_pkg::uls_cfg_t cfg;
    logic [7:0] scratch;
    logic [7:0] rdata;
    logic rd_ok;
    logic [CW-1:0] rx_count;
    logic [CW-1:0] err_count;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic head_new;
    logic parity_error;
    logic framing_error;
    logic break_seen;
    logic overrun;
    logic [11:0] low_cnt;
    logic brk_hold;
    logic zero_push;
    logic resync;
    logic [11:0] to_cnt;
    logic timeout;
    logic rx_reached;
    logic [CW-1:0] tx_count;
    logic tx_full_seen;
    logic cts_prev;
    logic cts_delta;
  } uls_state_t;

  uls_state_t s_r;
  uls_state_t s_nxt;
  uls_pkg::uls_tag_t head_tag;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [AW-1:0] mem_raddr;
  uls_pkg::uls_tag_t mem_wdata;

  // Decodes a mapped register offset
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == uls_pkg::OFF_LINE_STATUS) ||
              (a == uls_pkg::OFF_MODEM_STATUS) ||
              (a == uls_pkg::OFF_SCRATCH) ||
              (a == uls_pkg::OFF_DMA_READY) ||
              (a == uls_pkg::OFF_CONFIG);
  endfunction

  // Receive trigger threshold
  function automatic logic [CW-1:0] trig_level(input logic [1:0] code);
    unique case (code)
      2'h0: trig_level = CW'(uls_pkg::TRIG_LEVEL_0);
      2'h1: trig_level = CW'(uls_pkg::TRIG_LEVEL_1);
      2'h2: trig_level = CW'(uls_pkg::TRIG_LEVEL_2);
      2'h3: trig_level = CW'(uls_pkg::TRIG_LEVEL_3);
    endcase
  endfunction

  uls_tag_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_tag_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(head_tag)
  );

  logic acc;
  logic rd_lsr;
  logic rd_msr;
  logic fmode;
  logic mode1;
  logic [CW-1:0] lim;
  logic [11:0] frame_ticks;
  logic [11:0] to_lim;
  logic brk_evt;
  logic push;
  logic pop;
  logic full;
  logic ovr;
  logic do_write;
  uls_pkg::uls_tag_t tag_in;
  logic [7:0] lsr;
  logic [7:0] msr;
  logic [7:0] dsr;
  logic cts_now;
  logic tx_mode1_rdy;

  always_comb
  begin
    s_nxt = s_r;
    acc = psel && penable && s_r.rd_ok && ce;
    rd_lsr = acc && !pwrite && paddr == uls_pkg::OFF_LINE_STATUS;
    rd_msr = acc && !pwrite && paddr == uls_pkg::OFF_MODEM_STATUS;
    fmode = s_r.cfg.fifo_enable;
    mode1 = s_r.cfg.dma_mode_select && s_r.cfg.fifo_enable;
    lim = fmode ? DEPTH_C : ONE_C;
    cts_now = !cts_n;

    // Status views built from current state
    lsr = '0;
    lsr[uls_pkg::LSR_RX_FIFO_ERROR] = fmode && s_r.err_count != '0;
    lsr[uls_pkg::LSR_TRANSMITTER_EMPTY] =
      s_r.tx_count == '0 && !tx_shift_busy;
    lsr[uls_pkg::LSR_HOLDING_EMPTY] = s_r.tx_count == '0;
    lsr[uls_pkg::LSR_BREAK_SEEN] = s_r.break_seen;
    lsr[uls_pkg::LSR_FRAMING_ERROR] = s_r.framing_error;
    lsr[uls_pkg::LSR_PARITY_ERROR] = s_r.parity_error;
    lsr[uls_pkg::LSR_OVERRUN] = s_r.overrun;
    lsr[uls_pkg::LSR_RX_DATA_READY] = s_r.rx_count != '0;
    msr = '0;
    msr[uls_pkg::MSR_CLEAR_TO_SEND] = s_r.cts_prev;
    msr[uls_pkg::MSR_CLEAR_TO_SEND_DELTA] = s_r.cts_delta;
    tx_mode1_rdy = s_r.tx_full_seen;
    dsr = '0;
    dsr[uls_pkg::DSR_TX_DMA_READY] =
      mode1 ? tx_mode1_rdy : s_r.tx_count != '0;
    dsr[uls_pkg::DSR_RX_DMA_READY] =
      mode1 ? !s_r.rx_reached : s_r.rx_count == '0;

    // APB: capture read data while selected, answer in the access phase
    s_nxt.rd_ok = psel && !acc;
    if (psel)
    begin
      unique case (paddr)
        uls_pkg::OFF_LINE_STATUS: s_nxt.rdata = lsr;
        uls_pkg::OFF_MODEM_STATUS: s_nxt.rdata = msr;
        uls_pkg::OFF_SCRATCH: s_nxt.rdata = s_r.scratch;
        uls_pkg::OFF_DMA_READY: s_nxt.rdata = dsr;
        uls_pkg::OFF_CONFIG: s_nxt.rdata = s_r.cfg;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    if (acc && pwrite && paddr == uls_pkg::OFF_SCRATCH)
      s_nxt.scratch = pwdata[7:0];
    if (acc && pwrite && paddr == uls_pkg::OFF_CONFIG)
      s_nxt.cfg = uls_pkg::uls_cfg_t'(pwdata[7:0]);

    // Break detection on the raw serial input
    frame_ticks = 12'(uls_pkg::TICKS_PER_BIT *
      (uls_pkg::START_STOP_BITS + uls_pkg::MIN_DATA_BITS +
       int'(s_r.cfg.word_len) + int'(s_r.cfg.parity_en)));
    to_lim = 12'(uls_pkg::TIMEOUT_CHARS * int'(frame_ticks));
    brk_evt = baud_tick && !serial_input_pin &&
      s_r.low_cnt == frame_ticks && !s_r.brk_hold;
    if (serial_input_pin)
      s_nxt.low_cnt = '0;
    else if (baud_tick && s_r.low_cnt != 12'hfff)
      s_nxt.low_cnt = s_r.low_cnt + 12'h001;
    if (brk_evt)
      s_nxt.brk_hold = 1'b1;
    else if (serial_input_pin)
      s_nxt.brk_hold = 1'b0;
    s_nxt.zero_push = brk_evt;

    // Receive occupancy and tag storage
    tag_in = rx_evt.tag;
    if (brk_evt)
      tag_in = '{break_seen: 1'b1, framing_error: 1'b0, parity_error: 1'b0};
    push = brk_evt || (rx_evt.push && !s_r.brk_hold);
    pop = rx_buf_read && s_r.rx_count != '0;
    full = s_r.rx_count == lim;
    ovr = push && full && !pop;
    do_write = push && (!ovr || !fmode);
    s_nxt.resync = rx_evt.push && rx_evt.tag.framing_error;
    mem_we = do_write;
    mem_wdata = tag_in;
    mem_waddr = fmode ? s_r.wp : '0;
    if (do_write && fmode)
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + AW'(1);
    if (pop && fmode)
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + AW'(1);
    mem_raddr = fmode ? s_nxt.rp : '0;
    if (!fmode && do_write)
      s_nxt.rx_count = ONE_C;
    else if (do_write && !pop)
      s_nxt.rx_count = s_r.rx_count + ONE_C;
    else if (pop && !do_write)
      s_nxt.rx_count = s_r.rx_count - ONE_C;
    if (do_write && |tag_in && (fmode || !(pop || ovr)))
      s_nxt.err_count = s_nxt.err_count + ONE_C;
    if ((pop || (ovr && !fmode)) && |head_tag && s_r.err_count != '0)
      s_nxt.err_count = s_nxt.err_count - ONE_C;
    s_nxt.head_new = (pop && s_r.rx_count > ONE_C) ||
      (do_write && (!fmode || s_r.rx_count == '0 ||
       (pop && s_r.rx_count == ONE_C)));

    // Error flags: read clears only bits already reported, events win
    if (rd_lsr)
    begin
      s_nxt.break_seen = s_r.break_seen &&
        !s_r.rdata[uls_pkg::LSR_BREAK_SEEN];
      s_nxt.framing_error = s_r.framing_error &&
        !s_r.rdata[uls_pkg::LSR_FRAMING_ERROR];
      s_nxt.parity_error = s_r.parity_error &&
        !s_r.rdata[uls_pkg::LSR_PARITY_ERROR];
      s_nxt.overrun = s_r.overrun &&
        !s_r.rdata[uls_pkg::LSR_OVERRUN];
    end
    if (!fmode && rx_evt.push && !rx_evt.tag.framing_error &&
        !rx_evt.tag.break_seen)
      s_nxt.break_seen = 1'b0;
    if (s_r.head_new)
    begin
      s_nxt.break_seen = head_tag.break_seen || s_nxt.break_seen;
      s_nxt.framing_error = head_tag.framing_error;
      s_nxt.parity_error = head_tag.parity_error;
    end
    if (ovr)
      s_nxt.overrun = 1'b1;

    // Character time-out
    if (push || pop || s_r.rx_count == '0)
    begin
      s_nxt.to_cnt = '0;
      s_nxt.timeout = 1'b0;
    end
    else if (baud_tick && !s_r.timeout)
    begin
      s_nxt.to_cnt = s_r.to_cnt + 12'h001;
      if (s_r.to_cnt + 12'h001 >= to_lim)
        s_nxt.timeout = 1'b1;
    end

    // Receive ready latch for DMA mode 1
    if (s_nxt.rx_count == '0)
      s_nxt.rx_reached = 1'b0;
    else if (s_nxt.rx_count >= trig_level(s_r.cfg.rx_trigger_level) ||
             s_nxt.timeout)
      s_nxt.rx_reached = 1'b1;

    // Transmit occupancy
    if (tx_write && !tx_load_shift && s_r.tx_count != lim)
      s_nxt.tx_count = s_r.tx_count + ONE_C;
    else if (tx_load_shift && !tx_write && s_r.tx_count != '0)
      s_nxt.tx_count = s_r.tx_count - ONE_C;
    if (s_nxt.tx_count == DEPTH_C)
      s_nxt.tx_full_seen = 1'b1;
    else if (s_nxt.tx_count == '0)
      s_nxt.tx_full_seen = 1'b0;

    // Modem status delta: a change beats a clearing read
    s_nxt.cts_prev = cts_now;
    if (rd_msr && s_r.rdata[uls_pkg::MSR_CLEAR_TO_SEND_DELTA])
      s_nxt.cts_delta = 1'b0;
    if (cts_now != s_r.cts_prev)
      s_nxt.cts_delta = 1'b1;

    // Switching FIFO mode empties the queues
    if (s_nxt.cfg.fifo_enable != s_r.cfg.fifo_enable)
    begin
      s_nxt.rx_count = '0;
      s_nxt.err_count = '0;
      s_nxt.tx_count = '0;
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.head_new = 1'b0;
      s_nxt.rx_reached = 1'b0;
      s_nxt.tx_full_seen = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.scratch <= uls_pkg::RST_SCRATCH;
      s_r.cfg <= uls_pkg::uls_cfg_t'(uls_pkg::RST_CONFIG);
    end
    else if (ce)
      s_r <= s_nxt;
  end

  assign pready = psel && penable && s_r.rd_ok && ce;
  assign pslverr = pready && !reg_hit(paddr);
  assign prdata = {24'h000000, s_r.rdata};
  assign rx_zero_push = s_r.zero_push;
  assign rx_hold_off = s_r.brk_hold;
  assign rx_resync = s_r.resync;
  assign rx_timeout = s_r.timeout;
  assign modem_status_irq =
    s_r.cts_delta && s_r.cfg.modem_status_irq_enable;
  assign tx_dma_ready = s_r.cfg.dma_mode_select && s_r.cfg.fifo_enable ?
    s_r.tx_full_seen : s_r.tx_count != '0;
  assign rx_dma_ready = s_r.cfg.dma_mode_select && s_r.cfg.fifo_enable ?
    !s_r.rx_reached : s_r.rx_count == '0;
  assign fifo_enable = s_r.cfg.fifo_enable;

endmodule

// ==== uls_status_checker.sv ====
// Concurrent checks on the ports of the serial line status block
`timescale 1ns/1ps
module uls_status_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_input_pin,
  input wire uls_pkg::uls_rx_evt_t rx_evt,
  input wire logic tx_write,
  input wire logic tx_load_shift,
  input wire logic rx_zero_push,
  input wire logic rx_hold_off,
  input wire logic rx_resync,
  input wire logic tx_dma_ready,
  input wire logic rx_dma_ready,
  input wire logic fifo_enable
);
  default clocking
    @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && ce;
  endsequence
  sequence s_rx_take;
    rx_evt.push && ce && !rx_hold_off;
  endsequence
  property p_zero_wait;
    s_setup ##1 s_access |-> pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_frozen;
    !ce |-> !pready;
  endproperty
  property p_resync;
    s_rx_take ##0 rx_evt.tag.framing_error |=> rx_resync;
  endproperty
  property p_rx_empty;
    !fifo_enable ##0 s_rx_take |-> ##[1:2] !rx_dma_ready;
  endproperty
  property p_tx_ready;
    ce && !fifo_enable && tx_write && !tx_load_shift |-> ##[1:2] tx_dma_ready;
  endproperty
  property p_zero_once;
    rx_zero_push && ce |-> rx_hold_off ##1 !rx_zero_push;
  endproperty
  property p_hold;
    rx_hold_off && !serial_input_pin |=> rx_hold_off;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("pready missing in access cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");
  a_frozen: assert property (p_frozen)
    else $error("pready while clock enable low");
  a_resync: assert property (p_resync)
    else $error("no resync after framing error");
  a_rx_empty: assert property (p_rx_empty)
    else $error("rx dma ready kept with data held");
  a_tx_ready: assert property (p_tx_ready)
    else $error("tx dma ready missing after write");
  a_zero_once: assert property (p_zero_once)
    else $error("zero push not single or hold missing");
  a_hold: assert property (p_hold)
    else $error("hold off dropped while line low");
endmodule

bind uls_status uls_status_checker u_chk (
  .pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
  .serial_input_pin, .rx_evt, .tx_write, .tx_load_shift, .rx_zero_push,
  .rx_hold_off, .rx_resync, .tx_dma_ready, .rx_dma_ready, .fifo_enable
);

// ==== uls_peer_model.sv ====
// Far-side serial peer: drives the receive line and clear-to-send
`timescale 1ns/1ps
module uls_peer_model (
  input wire logic pclk,
  output logic serial_input_pin,
  output logic cts_n
);
  initial
  begin
    serial_input_pin = 1'b1;
    cts_n = 1'b1;
  end
  // Peer readiness, active low on the wire
  task set_ready(input logic on);
    @(posedge pclk);
    cts_n <= !on;
  endtask
  // Line held low for n cycles, then back to mark
  task send_break(input int n);
    @(posedge pclk);
    serial_input_pin <= 1'b0;
    repeat (n) @(posedge pclk);
    serial_input_pin <= 1'b1;
  endtask
endmodule

// ==== uart_line_modem_dma_status_test.sv ====
// Self-checking bench for the serial line status block
`timescale 1ns/1ps
module uart_line_modem_dma_status_test;
  localparam logic [7:0] LS = uls_pkg::OFF_LINE_STATUS;
  localparam logic [7:0] MS = uls_pkg::OFF_MODEM_STATUS;
  localparam logic [7:0] SC = uls_pkg::OFF_SCRATCH;
  localparam logic [7:0] DS = uls_pkg::OFF_DMA_READY;
  localparam logic [7:0] CF = uls_pkg::OFF_CONFIG;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic serial_input_pin, baud_tick, rx_buf_read, tx_write, tx_load_shift;
  logic tx_shift_busy, cts_n, rx_zero_push, rx_hold_off, rx_resync;
  logic rx_timeout, modem_status_irq, tx_dma_ready, rx_dma_ready;
  logic fifo_enable;
  uls_pkg::uls_rx_evt_t rx_evt;
  int bad_count, tests_run, k;
  int lv[4];
  uls_status dut (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .serial_input_pin(serial_input_pin),
    .baud_tick(baud_tick),
    .rx_evt(rx_evt),
    .rx_buf_read(rx_buf_read),
    .tx_write(tx_write),
    .tx_load_shift(tx_load_shift),
    .tx_shift_busy(tx_shift_busy),
    .cts_n(cts_n),
    .rx_zero_push(rx_zero_push),
    .rx_hold_off(rx_hold_off),
    .rx_resync(rx_resync),
    .rx_timeout(rx_timeout),
    .modem_status_irq(modem_status_irq),
    .tx_dma_ready(tx_dma_ready),
    .rx_dma_ready(rx_dma_ready),
    .fifo_enable(fifo_enable)
  );
  uls_peer_model peer (
    .pclk(pclk),
    .serial_input_pin(serial_input_pin),
    .cts_n(cts_n)
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      bad_count++;
      stop_test;
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rv, e);
  endtask
  // m: 1 push, 2 buffer read, 4 tx write, 8 load shifter
  task automatic pulse(input logic [3:0] m, input uls_pkg::uls_tag_t t);
    rx_evt.push <= m[0];
    rx_evt.tag <= t;
    rx_buf_read <= m[1];
    tx_write <= m[2];
    tx_load_shift <= m[3];
    @(posedge pclk);
    rx_evt <= '0;
    rx_buf_read <= 1'b0;
    tx_write <= 1'b0;
    tx_load_shift <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    stop_test;
  end
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    baud_tick = 1'b1;
    rx_buf_read = 1'b0;
    tx_write = 1'b0;
    tx_load_shift = 1'b0;
    tx_shift_busy = 1'b0;
    rx_evt = '0;
    bad_count = 0;
    tests_run = 0;
    lv = '{1, 4, 8, 14};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    rd("line", LS, 32'h06);
    rd("dma", DS, 32'h80);
    rd("modem", MS, 32'h00);
    rd("config", CF, 32'h00);
    rd("scratch", SC, 32'h00);
    apb(1'b1, SC, 32'ha5);
    rd("scratch", SC, 32'ha5);
    // Clock enable low stalls the access until it returns
    ce <= 1'b0;
    fork
      rd("scratch", SC, 32'ha5);
      begin
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    apb(1'b1, DS, 32'hff);
    rd("dma", DS, 32'h80);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", rv, 32'h0);
    chk("slverr", er, 32'h1);
    apb(1'b1, CF, 32'h01);
    chk("fifo en", fifo_enable, 32'h1);
    pulse(4'h1, 3'b001);
    rd("line", LS, 32'ha7);
    rd("line", LS, 32'h87);
    pulse(4'h1, 3'b010);
    rd("line", LS, 32'h87);
    pulse(4'h2, 3'b000);
    rd("line", LS, 32'h97);
    pulse(4'h2, 3'b000);
    rd("line", LS, 32'h06);
    peer.send_break(130);
    repeat (4) @(posedge pclk);
    rd("line", LS, 32'h8f);
    pulse(4'h2, 3'b000);
    rd("line", LS, 32'h06);
    apb(1'b1, CF, 32'h00);
    chk("fifo en", fifo_enable, 32'h0);
    pulse(4'h1, 3'b000);
    pulse(4'h1, 3'b010);
    rd("line", LS, 32'hd6);
    rd("line", LS, 32'h86);
    pulse(4'h2, 3'b000);
    rd("line", LS, 32'h06);
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, CF, 32'h03 | 32'(k << 2));
      repeat (lv[k] - 1) pulse(4'h1, 3'b000);
      chk("rx rdy", rx_dma_ready, 32'h1);
      pulse(4'h1, 3'b000);
      chk("rx rdy", rx_dma_ready, 32'h0);
      repeat (lv[k] - 1) pulse(4'h2, 3'b000);
      chk("rx rdy", rx_dma_ready, 32'h0);
      pulse(4'h2, 3'b000);
      chk("rx rdy", rx_dma_ready, 32'h1);
    end
    // Seventeenth character into a full FIFO is dropped
    repeat (17) pulse(4'h1, 3'b000);
    rd("line", LS, 32'hc6);
    repeat (15) pulse(4'h2, 3'b000);
    rd("line", LS, 32'h86);
    pulse(4'h2, 3'b000);
    rd("line", LS, 32'h06);
    pulse(4'h1, 3'b000);
    repeat (400) @(posedge pclk);
    chk("timeout", rx_timeout, 32'h0);
    repeat (100) @(posedge pclk);
    chk("timeout", rx_timeout, 32'h1);
    chk("rx rdy", rx_dma_ready, 32'h0);
    pulse(4'h2, 3'b000);
    apb(1'b1, CF, 32'h02);
    pulse(4'h4, 3'b000);
    rd("line", LS, 32'h00);
    rd("dma", DS, 32'hc0);
    tx_shift_busy <= 1'b1;
    pulse(4'h8, 3'b000);
    rd("line", LS, 32'h04);
    rd("dma", DS, 32'h80);
    tx_shift_busy <= 1'b0;
    rd("line", LS, 32'h06);
    apb(1'b1, CF, 32'h03);
    repeat (15) pulse(4'h4, 3'b000);
    chk("tx rdy", tx_dma_ready, 32'h0);
    pulse(4'h4, 3'b000);
    chk("tx rdy", tx_dma_ready, 32'h1);
    repeat (15) pulse(4'h8, 3'b000);
    chk("tx rdy", tx_dma_ready, 32'h1);
    pulse(4'h8, 3'b000);
    chk("tx rdy", tx_dma_ready, 32'h0);
    rd("line", LS, 32'h06);
    peer.set_ready(1'b1);
    repeat (3) @(posedge pclk);
    rd("modem", MS, 32'h88);
    rd("modem", MS, 32'h08);
    apb(1'b1, CF, 32'h10);
    peer.set_ready(1'b0);
    repeat (3) @(posedge pclk);
    chk("irq", modem_status_irq, 32'h1);
    rd("modem", MS, 32'h80);
    chk("irq", modem_status_irq, 32'h0);
    stop_test;
  end
endmodule
